// file: core/bridge_type1_header_regs.v
// type 1 bridge header register bank with APB slave and I/O window decode
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`include "bridge_hdr_defines.vh"

module bridge_type1_header_regs #(
  parameter ADDR_W = 12
) (
  input  wire              CLK_I,
  input  wire              RESET_N_I,
  input  wire              PSEL_I,
  input  wire              PENABLE_I,
  input  wire              PWRITE_I,
  input  wire [ADDR_W-1:0] PADDR_I,
  input  wire [31:0]       PWDATA_I,
  output reg  [31:0]       PRDATA_O,
  output reg               PREADY_O,
  output reg               PSLVERR_O,
  input  wire              IO_REQ_VALID_I,
  input  wire [31:0]       IO_REQ_ADDR_I,
  output reg               IO_FWD_VALID_O,
  output reg               IO_FWD_O,
  output reg               IO_CAP_O
);

  ////////////////////////////////////////////////////////////////////////////////
  // storage
  reg  [7:0] upstream_bus_q;
  reg  [7:0] downstream_bus_q;
  reg  [7:0] highest_bus_q;
  reg        io_cap_q;
  reg  [3:0] io_base_q;
  reg  [3:0] io_limit_q;
  reg        lock_q;

  wire [9:0] index;
  wire       setup;
  wire       wr_en;
  reg  [31:0] rd_word;
  reg         rd_hit;
  wire [7:0]  io_low_byte;
  wire [7:0]  io_high_byte;
  wire [31:0] win_lo;
  wire [31:0] win_hi;

  // word index; byte lanes below bit 2 are ignored
  assign index = PADDR_I[ADDR_W-1:2];
  assign setup = PSEL_I & ~PENABLE_I;
  // write lands only at the edge where the access phase sees ready
  assign wr_en = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;

  assign io_low_byte  = {io_base_q, 3'h0, io_cap_q};
  assign io_high_byte = {io_limit_q, 3'h0, io_cap_q};

  ////////////////////////////////////////////////////////////////////////////////
  // read mux, also flags unmapped addresses
  always @*
  begin
    rd_word = `ZERO_WORD;
    rd_hit  = 1'b1;
    if (index == `IDX_HEADER_KIND)
      rd_word = {24'h00_0000, `HEADER_KIND_VAL};
    else if (index == `IDX_SELF_TEST)
      rd_word = {24'h00_0000, `ZERO_BYTE};
    else if (index == `IDX_UNUSED_BASE_0 || index == `IDX_UNUSED_BASE_1)
      rd_word = `ZERO_WORD;
    else if (index == `IDX_UPSTREAM_BUS)
      rd_word = {24'h00_0000, upstream_bus_q};
    else if (index == `IDX_DOWNSTREAM_BUS)
      rd_word = {24'h00_0000, downstream_bus_q};
    else if (index == `IDX_HIGHEST_BUS)
      rd_word = {24'h00_0000, highest_bus_q};
    else if (index == `IDX_DOWNSTREAM_LAT)
      rd_word = {24'h00_0000, `ZERO_BYTE};
    else if (index == `IDX_IO_WINDOW_LOW)
      rd_word = {24'h00_0000, io_low_byte};
    else if (index == `IDX_IO_WINDOW_HIGH)
      rd_word = {24'h00_0000, io_high_byte};
    else if (index == `IDX_LOCK_CTRL)
      rd_word = {31'h0000_0000, lock_q};
    else
      rd_hit = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb answer: one wait-free access phase, data and error from flops
  always @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      PRDATA_O  <= `ZERO_WORD;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
    else if (setup)
    begin
      PREADY_O  <= 1'b1;
      PSLVERR_O <= ~rd_hit;
      PRDATA_O  <= PWRITE_I ? `ZERO_WORD : rd_word;
    end
    else
    begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // writable fields; read-only registers simply drop writes
  always @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      upstream_bus_q   <= `ZERO_BYTE;
      downstream_bus_q <= `ZERO_BYTE;
      highest_bus_q    <= `ZERO_BYTE;
      io_cap_q         <= `IO_CAP_RST;
      io_base_q        <= `IO_BASE_RST;
      io_limit_q       <= `IO_LIMIT_RST;
      lock_q           <= `LOCK_RST;
    end
    else if (wr_en)
    begin
      if (index == `IDX_UPSTREAM_BUS)
        upstream_bus_q <= PWDATA_I[7:0];
      else if (index == `IDX_DOWNSTREAM_BUS)
        downstream_bus_q <= PWDATA_I[7:0];
      else if (index == `IDX_HIGHEST_BUS)
        highest_bus_q <= PWDATA_I[7:0];
      else if (index == `IDX_IO_WINDOW_LOW)
      begin
        io_base_q <= PWDATA_I[`IO_ADDR_MSB:`IO_ADDR_LSB];
        if (!lock_q)
          io_cap_q <= PWDATA_I[`IO_CAP_BIT];
      end
      else if (index == `IDX_IO_WINDOW_HIGH)
        io_limit_q <= PWDATA_I[`IO_ADDR_MSB:`IO_ADDR_LSB];
      else if (index == `IDX_LOCK_CTRL)
        lock_q <= PWDATA_I[`LOCK_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // window bounds; upper 16 bits live outside this bank, taken as zero
  // limit low 12 bits are ones
  assign win_lo = {`IO_UPPER_ZERO, io_base_q, `IO_LOW_PAGE};
  assign win_hi = {`IO_UPPER_ZERO, io_limit_q, `IO_HIGH_PAGE};

  // forward decision from base and limit
  // inclusive range compare; base above limit forwards nothing
  always @(posedge CLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
    begin
      IO_FWD_VALID_O <= 1'b0;
      IO_FWD_O       <= 1'b0;
      IO_CAP_O       <= `IO_CAP_RST;
    end
    else
    begin
      IO_FWD_VALID_O <= IO_REQ_VALID_I;
      IO_FWD_O       <= IO_REQ_VALID_I & (IO_REQ_ADDR_I >= win_lo)
                        & (IO_REQ_ADDR_I <= win_hi);
      IO_CAP_O       <= io_cap_q; // registered copy of the width flag
    end
  end

endmodule // bridge_type1_header_regs

// file: core/bridge_hdr_defines.vh
// constants for the type 1 bridge header register bank
`ifndef BRIDGE_HDR_DEFINES_VH
`define BRIDGE_HDR_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// register indices; byte address is four times the index
`define IDX_HEADER_KIND      10'h000e
`define IDX_SELF_TEST        10'h000f
`define IDX_UNUSED_BASE_0    10'h0010
`define IDX_UNUSED_BASE_1    10'h0014
`define IDX_UPSTREAM_BUS     10'h0018
`define IDX_DOWNSTREAM_BUS   10'h0019
`define IDX_HIGHEST_BUS      10'h001a
`define IDX_DOWNSTREAM_LAT   10'h001b
`define IDX_IO_WINDOW_LOW    10'h001c
`define IDX_IO_WINDOW_HIGH   10'h001d
`define IDX_LOCK_CTRL        10'h0040

////////////////////////////////////////////////////////////////////////////////
// constant read values and reset values
`define HEADER_KIND_VAL      8'h01
`define ZERO_BYTE            8'h00
`define ZERO_WORD            32'h0000_0000
`define IO_CAP_RST           1'h1
`define IO_BASE_RST          4'hf
`define IO_LIMIT_RST         4'h0
`define LOCK_RST             1'h0
`define IO_LOW_PAGE          12'h000
`define IO_HIGH_PAGE         12'hfff
`define IO_UPPER_ZERO        16'h0000

////////////////////////////////////////////////////////////////////////////////
// field positions in the window registers and the lock control register
`define IO_CAP_BIT           0
`define IO_ADDR_MSB          7
`define IO_ADDR_LSB          4
`define LOCK_BIT             0

`endif

// file: sim/bridge_type1_header_regs_checker.sv
// port assertions for the bridge header register bank
`timescale 1ns/1ps
module bridge_type1_header_regs_checker #(
  parameter ADDR_W = 12
) (
  input wire logic              CLK_I,
  input wire logic              RESET_N_I,
  input wire logic              PSEL_I,
  input wire logic              PENABLE_I,
  input wire logic              PWRITE_I,
  input wire logic [ADDR_W-1:0] PADDR_I,
  input wire logic [31:0]       PWDATA_I,
  input wire logic [31:0]       PRDATA_O,
  input wire logic              PREADY_O,
  input wire logic              PSLVERR_O,
  input wire logic              IO_REQ_VALID_I,
  input wire logic [31:0]       IO_REQ_ADDR_I,
  input wire logic              IO_FWD_VALID_O,
  input wire logic              IO_FWD_O,
  input wire logic              IO_CAP_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // read setup and write access qualifiers
  wire rd_setup = PSEL_I && !PENABLE_I && !PWRITE_I;
  wire wr_acc   = PSEL_I && PENABLE_I && PWRITE_I;
  ////////////////////////////////////////////////////////////////////////////////
  property p_ready; PSEL_I && !PENABLE_I |=> PREADY_O ##1 !PREADY_O; endproperty
  a_ready: assert property (p_ready) else $error("ready not one cycle after setup");
  property p_hdr; rd_setup && PADDR_I == 12'h038 |=> PRDATA_O == 32'h0000_0001; endproperty
  a_hdr: assert property (p_hdr) else $error("header kind read wrong");
  property p_zero;
    rd_setup && PADDR_I inside {12'h03c, 12'h040, 12'h050, 12'h06c} |=> PRDATA_O == 32'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("constant zero register read wrong");
  property p_mirror; rd_setup && PADDR_I == 12'h074 |=> PRDATA_O[0] == IO_CAP_O; endproperty
  a_mirror: assert property (p_mirror) else $error("limit bit 0 not flag");
  property p_fwdv; IO_FWD_VALID_O == $past(IO_REQ_VALID_I); endproperty
  a_fwdv: assert property (p_fwdv) else $error("forward valid not one cycle late");
  property p_fwdq; !IO_FWD_VALID_O |-> !IO_FWD_O; endproperty
  a_fwdq: assert property (p_fwdq) else $error("forward without request");
  property p_high; IO_REQ_VALID_I && IO_REQ_ADDR_I[31:16] != 16'h0 |=> !IO_FWD_O; endproperty
  a_high: assert property (p_high) else $error("address above 64k forwarded");
  property p_cap; $changed(IO_CAP_O) |-> $past(wr_acc) || $past(wr_acc, 2); endproperty
  a_cap: assert property (p_cap) else $error("flag changed without write");
endmodule // bridge_type1_header_regs_checker
bind bridge_type1_header_regs bridge_type1_header_regs_checker #(.ADDR_W(ADDR_W)) u_chk (
  .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .IO_REQ_VALID_I(IO_REQ_VALID_I),
  .IO_REQ_ADDR_I(IO_REQ_ADDR_I), .IO_FWD_VALID_O(IO_FWD_VALID_O), .IO_FWD_O(IO_FWD_O),
  .IO_CAP_O(IO_CAP_O));

// file: sim/tb_bridge_type1_header_regs.sv
// self-checking bench for the bridge header register bank
`timescale 1ns/1ps
module tb_bridge_type1_header_regs;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, iov = 0, rerr;
  logic [11:0] paddr = 0;
  logic [31:0] pwd = 0, ioa = 0, rdat, prdata;
  logic pready, pslverr, fwdv, fwd, cap;
  int failures = 0, total_checks = 0;
  logic [9:0] ri [10] = '{10'h00e, 10'h00f, 10'h010, 10'h014, 10'h018, 10'h019, 10'h01a,
                          10'h01b, 10'h01c, 10'h01d};
  logic [7:0] rv [10] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hf1, 8'h01};
  logic [7:0] wv [10] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'hf1, 8'hf1};
  logic [31:0] ia [5] = '{32'h0000_2fff, 32'h0000_3000, 32'h0000_4fff, 32'h0000_5000,
                          32'h0001_3000};
  logic ie [5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  // free-running clock, half period 5 ns
  always #5 clk = ~clk;
  bridge_type1_header_regs #(.ADDR_W(12)) dut (
    .CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwd), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .IO_REQ_VALID_I(iov), .IO_REQ_ADDR_I(ioa), .IO_FWD_VALID_O(fwdv),
    .IO_FWD_O(fwd), .IO_CAP_O(cap));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; request held until ready is sampled high
  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= {idx, 2'b00};
    pwd <= d;
    @(posedge clk);
    pen <= 1;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20)
    begin
      failures++;
      final_report();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 0;
    pen <= 0;
  endtask
  // one i/o request, decode result checked the cycle after
  task automatic io(input logic [31:0] a, input logic e);
    @(posedge clk);
    iov <= 1;
    ioa <= a;
    @(posedge clk);
    iov <= 0;
    #1 chk({30'h0, fwdv, fwd}, {30'h0, 1'b1, e});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1;
    foreach (ri[i])
    begin
      apb(0, ri[i], 32'h0);
      chk(rdat, {24'h0, rv[i]});
    end
    $display("test reset values done");
    foreach (ri[i])
    begin
      apb(1, ri[i], 32'hffff_ffff);
      apb(0, ri[i], 32'h0);
      chk(rdat, {24'h0, wv[i]});
    end
    apb(1, 10'h01c, 32'h0000_0020);
    apb(0, 10'h01c, 32'h0);
    chk(rdat, 32'h0000_0020);
    apb(0, 10'h01d, 32'h0);
    chk(rdat, 32'h0000_00f0);
    chk({31'h0, cap}, 32'h0);
    $display("test access kinds done");
    apb(1, 10'h040, 32'h0000_0001);
    apb(1, 10'h01c, 32'h0000_0031);
    apb(0, 10'h01c, 32'h0);
    chk(rdat, 32'h0000_0030);
    apb(0, 10'h03f, 32'h0);
    chk({31'h0, rerr}, 32'h0000_0001);
    chk(rdat, 32'h0000_0000);
    $display("test lock and unmapped done");
    apb(1, 10'h01d, 32'h0000_0040);
    foreach (ia[i])
      io(ia[i], ie[i]);
    apb(1, 10'h018, 32'h0000_0055);
    io(32'h0000_3000, 1'b1);
    apb(1, 10'h01c, 32'h0000_0050);
    io(32'h0000_5000, 1'b0);
    $display("test window decode done");
    final_report();
  end
endmodule // tb_bridge_type1_header_regs
